// [hdl/cpuex_exec.sv]
// Execution unit for the multiply, negate, rotate, stack, repeat and return subset
// Operation
// - Two-word instructions form one 48-bit unit; second word top 8 bits zero.
// - A second word executed on its own does nothing.
// - Every two-word instruction takes exactly two cycles.
// - Single-word ops take one cycle, plus one on test, jump, table or register read.
// - Taken skip costs two cycles, or three over a two-word instruction.
// - Double-width moves always take two cycles.
// - Reading or modifying peripheral registers costs one extra cycle.
// - Pair multiply writes full product, high word to destination plus one, one cycle.
// - Multiply may write product into an accumulator in one cycle, flags untouched.
// - Low-word multiply writes only the low word, one cycle, flags untouched.
// - Negate writes inverse plus one and updates C, DC, N, OV and Z.
// - Double stack load and store move a register pair in two cycles, no flags.
// - Repeat runs the next instruction count plus one times; itself one cycle.
// - The three returns take six cycles, or five in the short case.
// - Rotate left through carry: old carry into bit zero, top bit to carry.
// - Plain rotate left: top bit into bit zero, carry untouched, N and Z only.
// - Rotate right through carry: old carry into top, bit zero to carry.
// - Plain rotate right: bit zero into top, carry untouched, N and Z only.
// - Sign widen writes the extended byte in one cycle, updating C, N and Z.
// - Power save picks sleep or idle by one bit, one cycle, touches status.
// - An accumulator operand selects exactly one of A or B.
`timescale 1ns/1ps

module cpuex_exec
  import cpuex_pkg::*;
#(
  parameter logic HAS_ACC = 1'b1
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Issue from the decoder
  input  wire logic              issue_i,
  input  wire cpuex_op_e         op_i,
  input  wire logic [EXT_W-1:0]  ext_word_i,
  input  wire logic              cond_true_i,
  input  wire logic              pc_change_i,
  input  wire logic              psv_read_i,
  input  wire logic              sfr_read_i,
  input  wire logic              skip_taken_i,
  input  wire logic              skip_two_i,
  input  wire logic              ret_short_i,
  // Operands
  input  wire logic [WORD_W-1:0] base_operand_reg_i,
  input  wire logic [WORD_W-1:0] source_operand_reg_i,
  input  wire logic              base_signed_i,
  input  wire logic              src_signed_i,
  input  wire logic              use_lit_i,
  input  wire logic [FIVE_BIT_LITERAL_W-1:0] five_bit_literal_i,
  input  wire logic [REPEAT_COUNT_LITERAL_W-1:0] repeat_count_literal_i,
  input  wire logic              rep_from_reg_i,
  input  wire logic              lit1_i,
  input  wire logic              acc_sel_i,
  input  wire logic              dst_default_i,
  input  wire logic              carry_i,
  // Sequencing
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   rep_active_o,
  output logic [REP_W-1:0]       rep_left_o,
  // Results
  output logic [WORD_W-1:0]      res_lo_o,
  output logic [WORD_W-1:0]      res_hi_o,
  output logic                   wr_lo_o,
  output logic                   wr_hi_o,
  output logic                   wr_default_o,
  output logic                   stack_we_o,
  output logic [FLG_W-1:0]       flags_o,
  output logic [FLG_W-1:0]       flag_we_o,
  output logic                   ext_err_o,
  output logic [WORD_W-1:0]      ext_payload_o,
  // Accumulator write
  output logic                   acc_wr_o,
  output logic                   acc_sel_o,
  output logic [ACC_W-1:0]       acc_val_o,
  // Power control
  output logic                   sleep_req_o,
  output logic                   idle_req_o,
  output logic                   pwr_stat_we_o
);

  // Operation class decode
  wire is_ext   = (op_i == OP_EXT_WORD);
  wire is_two   = (op_i == OP_TWO_WORD);
  wire is_skip  = (op_i == OP_SKIP);
  wire is_mov   = (op_i == OP_MOVE_DBL);
  wire is_pair  = (op_i == OP_PRODUCT_TO_PAIR);
  wire is_acc   = (op_i == OP_PRODUCT_TO_ACC);
  wire is_low   = (op_i == OP_PRODUCT_LOW_WORD);
  wire is_neg   = (op_i == OP_TWOS_COMPLEMENT_INVERT);
  wire is_pop   = (op_i == OP_STACK_LOAD_DBL);
  wire is_push  = (op_i == OP_STACK_STORE_DBL);
  wire is_rep   = (op_i == OP_REPEAT);
  wire is_rlit  = (op_i == OP_RETURN_WITH_LITERAL);
  wire is_ret   = is_rlit | (op_i == OP_RETURN_FROM_INTERRUPT) | (op_i == OP_RETURN_PLAIN);
  wire is_rlc   = (op_i == OP_ROTATE_LEFT_THRU_CARRY);
  wire is_rln   = (op_i == OP_ROTATE_LEFT_PLAIN);
  wire is_rrc   = (op_i == OP_ROTATE_RIGHT_THRU_CARRY);
  wire is_rrn   = (op_i == OP_ROTATE_RIGHT_PLAIN);
  wire is_sw    = (op_i == OP_SIGN_WIDEN);
  wire is_pwr   = (op_i == OP_POWER_SAVE);
  wire is_alu   = is_neg | is_rlc | is_rln | is_rrc | is_rrn | is_sw;
  wire is_dbl   = is_mov | is_pop | is_push;
  wire is_mul   = is_pair | is_low | is_acc;

  // Requests during a multi-cycle instruction are ignored by this unit while it is busy
  logic busy_r;
  wire  go = issue_i & ~busy_r;

  // Multiplier operands; a literal is always unsigned
  wire [WORD_W-1:0] s_opd = use_lit_i ?
                            {{(WORD_W-FIVE_BIT_LITERAL_W){1'b0}}, five_bit_literal_i} : source_operand_reg_i;
  wire a_sgn = base_signed_i & base_operand_reg_i[WORD_W-1];
  wire s_sgn = src_signed_i & ~use_lit_i & s_opd[WORD_W-1];
  wire signed [WORD_W:0]   a_x  = {a_sgn, base_operand_reg_i};
  wire signed [WORD_W:0]   s_x  = {s_sgn, s_opd};
  wire signed [MULX_W-1:0] prod = a_x * s_x;
  wire [2*WORD_W-1:0]      prod_w = prod[2*WORD_W-1:0];
  wire [ACC_W-1:0]         prod_acc = {{(ACC_W-MULX_W){prod[MULX_W-1]}}, prod};

  // Single-operand arithmetic on the source word
  wire [WORD_W-1:0] x = source_operand_reg_i;
  wire [WORD_W-1:0] neg_res = WORD_W'(~x + REP_ONE);
  wire [WORD_W-1:0] rlc_res = {x[WORD_W-2:0], carry_i};
  wire [WORD_W-1:0] rln_res = {x[WORD_W-2:0], x[WORD_W-1]};
  wire [WORD_W-1:0] rrc_res = {carry_i, x[WORD_W-1:1]};
  wire [WORD_W-1:0] rrn_res = {x[0], x[WORD_W-1:1]};
  wire [WORD_W-1:0] sw_res  = {{(WORD_W-BYTE_W){x[BYTE_W-1]}}, x[BYTE_W-1:0]};

  // Result select for the arithmetic ops
  wire [WORD_W-1:0] alu_res = is_neg ? neg_res :
                              is_rlc ? rlc_res :
                              is_rln ? rln_res :
                              is_rrc ? rrc_res :
                              is_rrn ? rrn_res :
                              sw_res;

  // Carry out of each op; plain rotates keep the incoming carry
  wire alu_c = is_neg ? (x == '0) :
               is_rlc ? x[WORD_W-1] :
               is_rrc ? x[0] :
               is_sw  ? ~x[BYTE_W-1] : carry_i;
  wire alu_dc = (x[NIB_W-1:0] == '0);
  wire alu_ov = (x == SIGN_ONLY);
  wire [FLG_W-1:0] alu_flg = {(alu_res == '0), alu_ov, alu_res[WORD_W-1], alu_dc, alu_c};
  wire [FLG_W-1:0] alu_we  = is_neg ? WE_ALL :
                             (is_rln | is_rrn) ? WE_NZ :
                             is_alu ? WE_CNZ : WE_NONE;

  // Cycle count per instruction
  wire extra = cond_true_i | pc_change_i | psv_read_i | sfr_read_i;
  wire [CNT_W-1:0] cyc_plain = extra ? CYC_TWO : CYC_ONE;
  wire [CNT_W-1:0] cyc_skip  = ~skip_taken_i ? CYC_ONE :
                               skip_two_i ? CYC_THREE : CYC_TWO;
  wire [CNT_W-1:0] cyc_ret   = ret_short_i ? CYC_RET_S : CYC_RET;
  wire [CNT_W-1:0] cyc_need  = is_ret ? cyc_ret :
                               is_skip ? cyc_skip :
                               (is_two | is_dbl) ? CYC_TWO :
                               (is_alu | (op_i == OP_PLAIN)) ? cyc_plain :
                               CYC_ONE;

  // Second word of a two-word unit must carry zeros in its top byte
  wire ext_ok = (ext_word_i[EXT_W-1:EXT_W-EXT_Z_W] == '0);

  // Next values of the result registers
  wire              wr_lo_nxt  = go & (is_pair | is_low | is_alu | is_pop | is_mov | is_rlit);
  wire              wr_hi_nxt  = go & (is_pair | is_pop | is_mov);
  wire              wr_def_nxt = go & is_alu & dst_default_i;
  wire              stk_we_nxt = go & is_push;
  wire              acc_wr_nxt = go & is_acc & HAS_ACC;
  wire [FLG_W-1:0]  fwe_nxt    = go ? alu_we : WE_NONE;
  wire              ext_err_nxt = go & is_two & ~ext_ok;
  wire [WORD_W-1:0] res_lo_nxt = is_mul ? prod_w[WORD_W-1:0] :
                                 is_alu ? alu_res :
                                 is_rlit ? source_operand_reg_i :
                                 base_operand_reg_i;
  wire [WORD_W-1:0] res_hi_nxt = is_mul ? prod_w[2*WORD_W-1:WORD_W] : source_operand_reg_i;

  // Instruction cycle counter
  logic [CNT_W-1:0] cnt_r;
  logic             done_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (go) begin
      cnt_r  <= cyc_need - CYC_ONE;
      busy_r <= (cyc_need != CYC_ONE);
      done_r <= (cyc_need == CYC_ONE);
    end else if (busy_r) begin
      cnt_r  <= cnt_r - CYC_ONE;                // Extra cycles run as empty slots
      busy_r <= (cnt_r != CYC_ONE);
      done_r <= (cnt_r == CYC_ONE);
    end else begin
      done_r <= 1'b0;
    end
  end

  // Repeat: count plus one executions of the following instruction
  logic [REP_W-1:0] rep_left_r;
  logic             rep_run_r;
  wire  [REP_W-1:0] rep_val = rep_from_reg_i ? source_operand_reg_i :
                              {1'b0, repeat_count_literal_i};
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rep_left_r <= '0;
      rep_run_r  <= 1'b0;
    end else if (go & is_rep) begin
      rep_left_r <= rep_val;
      rep_run_r  <= 1'b1;
    end else if (go & rep_run_r) begin
      rep_run_r  <= (rep_left_r != '0);         // Last pass ends the run
      rep_left_r <= (rep_left_r != '0) ? rep_left_r - REP_ONE : rep_left_r;
    end
  end

  // Write strobes are single-cycle pulses after the issue edge
  logic wr_lo_r, wr_hi_r, wr_def_r, stk_we_r, acc_wr_r, ext_err_r;
  logic [FLG_W-1:0] fwe_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_lo_r   <= 1'b0;
      wr_hi_r   <= 1'b0;
      wr_def_r  <= 1'b0;
      stk_we_r  <= 1'b0;
      acc_wr_r  <= 1'b0;
      ext_err_r <= 1'b0;
      fwe_r     <= WE_NONE;
    end else begin
      wr_lo_r   <= wr_lo_nxt & ~(is_two & ~ext_ok);
      wr_hi_r   <= wr_hi_nxt;
      wr_def_r  <= wr_def_nxt;
      stk_we_r  <= stk_we_nxt;
      acc_wr_r  <= acc_wr_nxt;
      ext_err_r <= ext_err_nxt;
      fwe_r     <= fwe_nxt;
    end
  end

  // Data registers hold their value until the next issue
  logic [WORD_W-1:0] res_lo_r, res_hi_r, ext_pl_r;
  logic [ACC_W-1:0]  acc_val_r;
  logic [FLG_W-1:0]  flags_r;
  logic              acc_sel_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res_lo_r  <= '0;
      res_hi_r  <= '0;
      ext_pl_r  <= '0;
      acc_val_r <= '0;
      flags_r   <= '0;
      acc_sel_r <= 1'b0;
    end else if (go) begin
      res_lo_r  <= res_lo_nxt;
      res_hi_r  <= res_hi_nxt;
      ext_pl_r  <= ext_word_i[WORD_W-1:0];
      acc_val_r <= prod_acc;
      flags_r   <= alu_flg;
      acc_sel_r <= acc_sel_i;
    end
  end

  // Power save requests; zero literal means sleep
  logic slp_r, idl_r, pst_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      slp_r <= 1'b0;
      idl_r <= 1'b0;
      pst_r <= 1'b0;
    end else begin
      slp_r <= go & is_pwr & ~lit1_i;
      idl_r <= go & is_pwr & lit1_i;
      pst_r <= go & is_pwr;
    end
  end

  // Outputs straight from flops
  assign busy_o        = busy_r;
  assign done_o        = done_r;
  assign rep_active_o  = rep_run_r;
  assign rep_left_o    = rep_left_r;
  assign res_lo_o      = res_lo_r;
  assign res_hi_o      = res_hi_r;
  assign wr_lo_o       = wr_lo_r;
  assign wr_hi_o       = wr_hi_r;
  assign wr_default_o  = wr_def_r;
  assign stack_we_o    = stk_we_r;
  assign flags_o       = flags_r;
  assign flag_we_o     = fwe_r;
  assign ext_err_o     = ext_err_r;
  assign ext_payload_o = ext_pl_r;
  assign acc_wr_o      = acc_wr_r;
  assign acc_sel_o     = acc_sel_r;
  assign acc_val_o     = acc_val_r;
  assign sleep_req_o   = slp_r;
  assign idle_req_o    = idl_r;
  assign pwr_stat_we_o = pst_r;

  // Checks on issue-to-result timing and values
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  ext_top_chk_a: assert property (go && is_two && !ext_ok |=> ext_err_o && !wr_lo_o)
    else $error("bad second word not flagged");
  orphan_nop_a: assert property (go && is_ext |=> !wr_lo_o && !wr_hi_o && flag_we_o == '0)
    else $error("orphan second word wrote something");
  two_word_cyc_a: assert property (go && is_two |=> busy_o && !done_o ##1 done_o && !busy_o)
    else $error("two-word op not two cycles");
  plain_cyc_a: assert property (go && op_i == OP_PLAIN && !extra |=> done_o && !busy_o)
    else $error("plain op not one cycle");
  skip_cyc_a: assert property (go && is_skip && skip_taken_i && skip_two_i
                               |=> !done_o ##1 !done_o ##1 done_o)
    else $error("skip over two words not three cycles");
  dbl_stack_a: assert property (go && is_pop |=> wr_lo_o && wr_hi_o && flag_we_o == '0
                                ##1 done_o)
    else $error("double stack load timing");
  pair_prod_a: assert property (go && is_pair |=> {res_hi_o, res_lo_o} == $past(prod_w)
                                && flag_we_o == '0 && done_o)
    else $error("pair product wrong");
  negate_val_a: assert property (go && is_neg |=> WORD_W'(res_lo_o + $past(x)) == '0
                                 && flag_we_o == WE_ALL)
    else $error("negate result wrong");
  rot_carry_a: assert property (go && is_rlc |=> res_lo_o == {$past(x[WORD_W-2:0]), $past(carry_i)}
                                && flags_o[FLG_C] == $past(x[WORD_W-1]))
    else $error("rotate through carry wrong");
  ret_long_a: assert property (go && is_ret && !ret_short_i |=> busy_o [*5] ##1 done_o)
    else $error("return not six cycles");
  repeat_run_a: assert property (go && is_rep |=> rep_active_o && done_o
                                 && rep_left_o == $past(rep_val))
    else $error("repeat not armed");
  pwr_sel_a: assert property (go && is_pwr |=> (sleep_req_o != idle_req_o) && pwr_stat_we_o
                              && idle_req_o == $past(lit1_i))
    else $error("power save select wrong");

  // Main scenarios
  acc_write_c: cover property (go && is_acc ##1 acc_wr_o);
  rep_done_c:  cover property (rep_active_o ##1 !rep_active_o);
  skip_c:      cover property (go && is_skip && skip_taken_i && !skip_two_i);

endmodule

// [hdl/cpuex_pkg.sv]
// Constants and op codes for the execution subset
package cpuex_pkg;

  // Data widths
  localparam int WORD_W  = 16;
  localparam int ACC_W   = 40;
  localparam int MULX_W  = 2 * WORD_W + 2;
  localparam int EXT_W   = 24;
  localparam int EXT_Z_W = 8;
  localparam int FIVE_BIT_LITERAL_W  = 5;
  localparam int REPEAT_COUNT_LITERAL_W = 15;
  localparam int BYTE_W  = 8;
  localparam int NIB_W   = 4;
  localparam int REP_W   = 16;
  localparam int CNT_W   = 3;
  localparam int FLG_W   = 5;

  // Status flag positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_N  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_Z  = 4;

  // Flag write masks
  localparam logic [FLG_W-1:0] WE_NONE = 5'h00;
  localparam logic [FLG_W-1:0] WE_ALL  = 5'h1f;
  localparam logic [FLG_W-1:0] WE_CNZ  = 5'h15;
  localparam logic [FLG_W-1:0] WE_NZ   = 5'h14;

  // Cycle counts
  localparam logic [CNT_W-1:0] CYC_ONE   = 3'h1;
  localparam logic [CNT_W-1:0] CYC_TWO   = 3'h2;
  localparam logic [CNT_W-1:0] CYC_THREE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_RET   = 3'h6;
  localparam logic [CNT_W-1:0] CYC_RET_S = 3'h5;

  // Fixed values
  localparam logic [WORD_W-1:0] SIGN_ONLY = 16'h8000;
  localparam logic [REP_W-1:0]  REP_ONE   = 16'h0001;

  // Operation classes handed in by the decoder
  typedef enum logic [4:0] {
    OP_PLAIN, OP_EXT_WORD, OP_TWO_WORD, OP_SKIP, OP_MOVE_DBL,
    OP_PRODUCT_TO_PAIR, OP_PRODUCT_TO_ACC, OP_PRODUCT_LOW_WORD,
    OP_TWOS_COMPLEMENT_INVERT, OP_STACK_LOAD_DBL, OP_STACK_STORE_DBL,
    OP_REPEAT, OP_RETURN_FROM_INTERRUPT, OP_RETURN_WITH_LITERAL,
    OP_RETURN_PLAIN, OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_PLAIN,
    OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_PLAIN, OP_SIGN_WIDEN,
    OP_POWER_SAVE
  } cpuex_op_e;

endpackage

// [sim/cpuex_regfile_model.sv]
// Working register file and carry holder on the far side of the execution unit
`timescale 1ns/1ps

module cpuex_regfile_model
  import cpuex_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Write side from the execution unit
  input  wire logic              wr_lo_i,
  input  wire logic              wr_hi_i,
  input  wire logic [WORD_W-1:0] res_lo_i,
  input  wire logic [WORD_W-1:0] res_hi_i,
  input  wire logic [FLG_W-1:0]  flags_i,
  input  wire logic [FLG_W-1:0]  flag_we_i,
  // Register contents and carry back to the core
  output logic [WORD_W-1:0]      dst_lo_o,
  output logic [WORD_W-1:0]      dst_hi_o,
  output logic                   carry_o
);
  logic [WORD_W-1:0] dst_lo_r;
  logic [WORD_W-1:0] dst_hi_r;
  logic              carry_r;

  // Destination and destination plus one only change on their own strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dst_lo_r <= '0;
      dst_hi_r <= '0;
      carry_r  <= 1'b0;
    end else begin
      if (wr_lo_i) begin
        dst_lo_r <= res_lo_i;
      end
      if (wr_hi_i) begin
        dst_hi_r <= res_hi_i;
      end
      // Carry kept only when its mask bit is set, so a plain rotate cannot disturb it
      if (flag_we_i[FLG_C]) begin
        carry_r <= flags_i[FLG_C];
      end
    end
  end

  // Outputs
  assign dst_lo_o = dst_lo_r;
  assign dst_hi_o = dst_hi_r;
  assign carry_o  = carry_r;
endmodule

// [sim/tb_cpuex_exec.sv]
// Self-checking bench for the execution subset
`timescale 1ns/1ps

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_cpuex_exec;
  import cpuex_pkg::*;

  logic              core_clk_i, rst_n_i, issue_i, carry;
  cpuex_op_e         op_i;
  logic [EXT_W-1:0]  ext_word_i;
  logic [13:0]       ctl;
  logic [WORD_W-1:0] base_v, src_v, res_lo, res_hi, pay, lo_m, hi_m;
  logic [FIVE_BIT_LITERAL_W-1:0] five_bit_literal;
  logic [REPEAT_COUNT_LITERAL_W-1:0] repeat_count_literal;
  logic              busy, done, rep_act, wlo, whi, stk, err, accw, accs, slp, idl, pst, wdef;
  logic [REP_W-1:0]  rep_left;
  logic [FLG_W-1:0]  flg, fwe, cap_fwe;
  logic [ACC_W-1:0]  accv;
  logic [7:0]        cap;
  int                mismatches, comparisons, n;

  // Control word bits: cond pc psv sfr skip skip2 short bsig ssig lit rreg lit1 acc dst
  cpuex_exec dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .op_i(op_i), .ext_word_i(ext_word_i),
    .cond_true_i(ctl[13]), .pc_change_i(ctl[12]), .psv_read_i(ctl[11]), .sfr_read_i(ctl[10]),
    .skip_taken_i(ctl[9]), .skip_two_i(ctl[8]), .ret_short_i(ctl[7]), .base_operand_reg_i(base_v),
    .source_operand_reg_i(src_v), .base_signed_i(ctl[6]), .src_signed_i(ctl[5]), .use_lit_i(ctl[4]),
    .five_bit_literal_i(five_bit_literal), .repeat_count_literal_i(repeat_count_literal), .rep_from_reg_i(ctl[3]), .lit1_i(ctl[2]),
    .acc_sel_i(ctl[1]), .dst_default_i(ctl[0]), .carry_i(carry), .busy_o(busy), .done_o(done),
    .rep_active_o(rep_act), .rep_left_o(rep_left), .res_lo_o(res_lo), .res_hi_o(res_hi), .wr_lo_o(wlo),
    .wr_hi_o(whi), .wr_default_o(wdef), .stack_we_o(stk), .flags_o(flg), .flag_we_o(fwe), .ext_err_o(err),
    .ext_payload_o(pay), .acc_wr_o(accw), .acc_sel_o(accs), .acc_val_o(accv), .sleep_req_o(slp),
    .idle_req_o(idl), .pwr_stat_we_o(pst));

  cpuex_regfile_model model (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wr_lo_i(wlo), .wr_hi_i(whi), .res_lo_i(res_lo),
    .res_hi_i(res_hi), .flags_i(flg), .flag_we_i(fwe), .dst_lo_o(lo_m), .dst_hi_o(hi_m), .carry_o(carry));

  // Full signed or unsigned product, worked out independently of the design
  function automatic logic [39:0] prod(input logic [15:0] a, input logic [15:0] b, input logic sa,
                                       input logic sb);
    logic signed [39:0] p;
    p = $signed({sa & a[15], a}) * $signed({sb & b[15], b});
    return p;
  endfunction

  // One accepted issue; captures cycle-one pulses, then waits for done under a bound
  task automatic run_op(input cpuex_op_e op, input logic [15:0] a, input logic [15:0] b,
                        input logic [13:0] c, input logic [23:0] aux);
    @(posedge core_clk_i);
    issue_i    <= 1'b1;
    op_i       <= op;
    base_v     <= a;
    src_v      <= b;
    ctl        <= c;
    ext_word_i <= aux;
    five_bit_literal       <= aux[4:0];
    repeat_count_literal      <= aux[14:0];
    @(posedge core_clk_i);
    issue_i <= 1'b0;
    #1;
    n       = 1;
    cap     = {wlo, whi, stk, err, accw, slp, idl, pst};
    cap_fwe = fwe;
    while (done !== 1'b1 && n < 10) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic t_cycles();
    cpuex_op_e   o[20] = '{OP_PLAIN, OP_PLAIN, OP_PLAIN, OP_PLAIN, OP_PLAIN, OP_PLAIN, OP_EXT_WORD,
                           OP_TWO_WORD, OP_SKIP, OP_SKIP, OP_SKIP, OP_MOVE_DBL, OP_STACK_LOAD_DBL,
                           OP_STACK_STORE_DBL, OP_RETURN_FROM_INTERRUPT, OP_RETURN_WITH_LITERAL,
                           OP_RETURN_PLAIN, OP_RETURN_PLAIN, OP_RETURN_FROM_INTERRUPT,
                           OP_TWOS_COMPLEMENT_INVERT};
    logic [13:0] c[20] = '{14'h0000, 14'h2000, 14'h1000, 14'h0800, 14'h0400, 14'h2400, 14'h0000,
                           14'h0000, 14'h0000, 14'h0200, 14'h0300, 14'h0000, 14'h0000, 14'h0000,
                           14'h0000, 14'h0000, 14'h0000, 14'h0080, 14'h0080, 14'h0400};
    int          e[20] = '{1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 3, 2, 2, 2, 6, 6, 6, 5, 5, 2};
    for (int i = 0; i < 20; i++) begin
      run_op(o[i], 16'h0012, 16'h0034, c[i], 24'h000055);
      `CHK(n, e[i])
      if (o[i] == OP_EXT_WORD || o[i] == OP_STACK_STORE_DBL) begin
        `CHK(cap[7], 1'b0)
        `CHK(cap_fwe, WE_NONE)
        `CHK(cap[5], o[i] == OP_STACK_STORE_DBL)
      end
    end
    `CHK(cap[5], 1'b0)
  endtask

  task automatic t_mul();
    logic [39:0] p;
    for (int i = 0; i < 4; i++) begin
      p = prod(16'hfffe, 16'h8003, i[1], i[0]);
      run_op(OP_PRODUCT_TO_PAIR, 16'hfffe, 16'h8003, {7'h00, i[1], i[0], 5'h00}, 24'h0);
      `CHK(n, 1)
      `CHK(cap_fwe, WE_NONE)
      @(posedge core_clk_i);
      #1;
      `CHK({hi_m, lo_m}, p[31:0])
      run_op(OP_PRODUCT_LOW_WORD, 16'hfffe, 16'h8003, {7'h00, i[1], i[0], 5'h00}, 24'h0);
      `CHK({cap[7:6], res_lo, cap_fwe}, {2'b10, p[15:0], WE_NONE})
      run_op(OP_PRODUCT_TO_ACC, 16'hfffe, 16'h8003, {7'h00, i[1], i[0], 3'h0, i[0], 1'b0}, 24'h0);
      `CHK({cap[3], accs, accv, cap_fwe}, {1'b1, i[0], p, WE_NONE})
    end
    p = prod(16'hfffe, 16'h001f, 1'b1, 1'b0);
    run_op(OP_PRODUCT_TO_ACC, 16'hfffe, 16'h8003, 14'h0072, 24'h00001f);
    `CHK({n[2:0], accs, accv}, {3'h1, 1'b1, p})
  endtask

  task automatic t_alu();
    cpuex_op_e   o[13] = '{OP_TWOS_COMPLEMENT_INVERT, OP_TWOS_COMPLEMENT_INVERT, OP_ROTATE_RIGHT_THRU_CARRY,
                           OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY, OP_TWOS_COMPLEMENT_INVERT,
                           OP_ROTATE_LEFT_PLAIN, OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_RIGHT_PLAIN,
                           OP_ROTATE_RIGHT_THRU_CARRY, OP_SIGN_WIDEN, OP_SIGN_WIDEN, OP_SIGN_WIDEN};
    logic [15:0] v[13] = '{16'h0000, 16'h8000, 16'h8001, 16'h0000, 16'h0000, 16'h0000, 16'h8001,
                           16'h8000, 16'h0001, 16'h0000, 16'h0080, 16'h007f, 16'h0000};
    logic [15:0] r[13] = '{16'h0000, 16'h8000, 16'h4000, 16'h0001, 16'h0000, 16'h0000, 16'h0003,
                           16'h0001, 16'h8000, 16'h8000, 16'hff80, 16'h007f, 16'h0000};
    logic [4:0]  f[13] = '{5'h13, 5'h0e, 5'h01, 5'h00, 5'h10, 5'h13, 5'h00, 5'h01, 5'h04, 5'h04,
                           5'h04, 5'h01, 5'h11};
    logic [4:0]  w[13] = '{WE_ALL, WE_ALL, WE_CNZ, WE_CNZ, WE_CNZ, WE_ALL, WE_NZ, WE_CNZ, WE_NZ,
                           WE_CNZ, WE_CNZ, WE_CNZ, WE_CNZ};
    // Operand placed in both sources; odd steps send the result to the default working register
    for (int i = 0; i < 13; i++) begin
      run_op(o[i], v[i], v[i], {13'h0000, i[0]}, 24'h0);
      `CHK({n[2:0], cap[7], wdef, res_lo}, {3'h1, 1'b1, i[0], r[i]})
      `CHK({flg & cap_fwe, cap_fwe}, {f[i], w[i]})
    end
  endtask

  task automatic t_misc();
    for (int i = 0; i < 2; i++) begin
      run_op(OP_POWER_SAVE, 16'h0, 16'h0, {11'h000, i[0], 2'h0}, 24'h0);
      `CHK({n[2:0], cap[2:0]}, {3'h1, ~i[0], i[0], 1'b1})
    end
    run_op(OP_TWO_WORD, 16'h0, 16'h0, 14'h0000, 24'h00a5c3);
    `CHK({cap[4], pay}, {1'b0, 16'ha5c3})
    run_op(OP_TWO_WORD, 16'h0, 16'h0, 14'h0000, 24'h80a5c3);
    `CHK(cap[7:4], 4'b0001)
    run_op(OP_REPEAT, 16'h0, 16'h0, 14'h0000, 24'h000002);
    `CHK({n[2:0], rep_act, rep_left}, {3'h1, 1'b1, 16'h0002})
    for (int i = 1; i >= -1; i--) begin
      run_op(OP_PLAIN, 16'h0, 16'h0, 14'h0000, 24'h0);
      `CHK(rep_act, i >= 0)
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Clock at 50 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Main sequence after two cycles of reset
  initial begin
    {rst_n_i, issue_i, ctl, base_v, src_v, ext_word_i, five_bit_literal, repeat_count_literal} = '0;
    op_i = OP_PLAIN;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK({busy, done, rep_act, res_lo}, 19'h0)
    t_cycles();
    t_mul();
    t_alu();
    t_misc();
    wrap_up();
  end

  // Whole run is well under a thousand cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge core_clk_i);
    mismatches++;
    wrap_up();
  end
endmodule
